//--- pps_map.vh
// register offsets, field layout, step codes and timing counts of the phase program sequencer
`ifndef PPS_MAP_VH
`define PPS_MAP_VH
// register byte offsets
`define PPS_REG_CTRL 8'h00
`define PPS_REG_KEY 8'h04
`define PPS_REG_PSEL 8'h08
`define PPS_REG_PDATA 8'h0c
`define PPS_REG_EDIT 8'h10
`define PPS_REG_STATUS 8'h14
`define PPS_REG_LABEL 8'h18
`define PPS_REG_RATE 8'h1c
`define PPS_REG_TOTALS 8'h20
// control register bits
`define PPS_CTRL_ALARM 0
`define PPS_CTRL_LOCKOUT 1
`define PPS_CTRL_START 4
`define PPS_CTRL_STOP 5
`define PPS_CTRL_PAUSE 6
// key codes
`define PPS_KEY_PHASE 2'h1
`define PPS_KEY_START 2'h2
`define PPS_KEY_OTHER 2'h3
// edit operations
`define PPS_EDIT_SELECT 2'h0
`define PPS_EDIT_INSERT 2'h1
`define PPS_EDIT_REMOVE 2'h2
// phase entry layout: func[28:25] dir[24] arg[23:16] rate[15:0]
`define PPS_ENT_W 29
`define PPS_ENT_FUNC_HI 28
`define PPS_ENT_FUNC_LO 25
`define PPS_ENT_DIR 24
`define PPS_ENT_ARG_HI 23
`define PPS_ENT_ARG_LO 16
`define PPS_ENT_RATE_HI 15
// step function codes
`define PPS_FN_RATE 4'h0
`define PPS_FN_RAISE 4'h1
`define PPS_FN_LOWER 4'h2
`define PPS_FN_HALT 4'h3
`define PPS_FN_GOTO 4'h4
`define PPS_FN_CHOICE 4'h5
`define PPS_FN_LABEL 4'h6
`define PPS_FN_OPEN 4'h7
`define PPS_FN_CLOSE 4'h8
`define PPS_FN_PAUSE 4'h9
// phase memory and label limits
`define PPS_MAX_PHASE 8'h28
`define PPS_LAST_IDX 6'h27
`define PPS_LABEL_MIN 7'h01
`define PPS_LABEL_MAX 7'h63
`define PPS_LOOP_DEPTH 3
// timing
`define PPS_CLK_PERIOD_NS 10
`define PPS_EDIT_TIMEOUT_MS 2000
`define PPS_EDIT_TIMEOUT_CYC 28'd200000000
`endif

//--- pps_phase_sequencer.v
// phase program sequencer: phase store, insert/remove editor and step executor behind apb
//
// Overview of operation
// - insert shifts selected phase through last up one, last phase is lost
// - inserted phase is a rate step at phase 1, a halt step elsewhere
// - remove drops selected phase and shifts higher phases down one
// - after insert or remove, goto targets are adjusted to follow their steps
// - edit needs phase key within 2 s; timeout or other key cancels
// - raise/lower step adds or subtracts operand from rate in force
// - raise/lower without base rate flags program error and halts
// - halt stops pump, ends program; next start begins at phase 1
// - advancing past the last phase acts as a halt step
// - with alarms on, buzzer sounds continuously after program stops
// - goto makes its operand the next phase
// - menu choice at phase 1 with lockout runs program at power-on
// - menu choice waits for label 1..99, start resumes at that label
// - confirming a menu choice clears dispense and withdraw totals
// - label search runs from current phase to end, wraps to phase 1
// - label not found shows out-of-range; any key returns to prompt
// - with duplicate labels the first match in search order wins
// - last chosen label is kept and offered as default next time
// - with alarms on, buzzer sounds while menu choice waits
// - label step met in sequence acts as a halt step
// - forever close returns to last unpaired open, else phase 1
// - foot start while held on continuous rate restarts at phase 1
// - highest phase is 40, larger phase numbers clamp to 40
`timescale 1ns/1ns
`include "pps_map.vh"

module pps_phase_sequencer #(
    parameter [27:0] EDIT_TIMEOUT_CYC = `PPS_EDIT_TIMEOUT_CYC
) (
    // clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // pump side
    input wire dose_done_in,
    input wire foot_switch_in,
    output reg pump_run_out,
    output reg pump_dir_out,
    output reg [15:0] pump_rate_out,
    output reg buzzer_out
);

    // executor states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_EXEC = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_PWAIT = 3'h3;
    localparam [2:0] ST_CHOICE = 3'h4;
    localparam [2:0] ST_SEARCH = 3'h5;
    localparam [2:0] ST_OOR = 3'h6;
    localparam [2:0] ST_HELD = 3'h7;

    reg [`PPS_ENT_W-1:0] mem [0:39];
    reg [2:0] state;
    reg [5:0] pc;
    reg [5:0] scan;
    reg [5:0] sel;
    reg [6:0] label;
    reg alarm_en;
    reg lockout_en;
    reg booted;
    reg base_valid;
    reg prog_error;
    reg stopped;
    reg oor;
    reg edit_armed;
    reg [1:0] edit_op;
    reg [27:0] edit_cnt;
    reg [15:0] total_disp;
    reg [15:0] total_wdraw;
    reg [5:0] loop_stk [0:`PPS_LOOP_DEPTH-1];
    reg [1:0] loop_sp;
    reg [2:0] foot_sync;
    reg foot_level;
    integer i;
    integer j;

    // one-based phase number to memory index, clamped to the last phase
    function [5:0] phase_index;
        input [7:0] n;
        begin
            if (n == 8'h00)
                phase_index = 6'h00;
            else if (n > `PPS_MAX_PHASE)
                phase_index = `PPS_LAST_IDX;
            else
                phase_index = n[5:0] - 6'h01;
        end
    endfunction

    // keep a goto target on the same logical step after a shift
    function [`PPS_ENT_W-1:0] fix_ref;
        input [`PPS_ENT_W-1:0] e;
        input ins;
        input [5:0] s;
        reg [7:0] t;
        reg [7:0] s1;
        begin
            t = e[`PPS_ENT_ARG_HI:`PPS_ENT_ARG_LO];
            s1 = {2'h0, s} + 8'h01;
            fix_ref = e;
            if (e[`PPS_ENT_FUNC_HI:`PPS_ENT_FUNC_LO] == `PPS_FN_GOTO) begin
                if (ins && t >= s1 && t < `PPS_MAX_PHASE)
                    fix_ref[`PPS_ENT_ARG_HI:`PPS_ENT_ARG_LO] = t + 8'h01;
                else if (!ins && t > s1)
                    fix_ref[`PPS_ENT_ARG_HI:`PPS_ENT_ARG_LO] = t - 8'h01;
            end
        end
    endfunction

    // fields of the current phase
    wire [`PPS_ENT_W-1:0] cur = mem[pc];
    wire [3:0] cur_fn = cur[`PPS_ENT_FUNC_HI:`PPS_ENT_FUNC_LO];
    wire [7:0] cur_arg = cur[`PPS_ENT_ARG_HI:`PPS_ENT_ARG_LO];
    wire [15:0] cur_rate = cur[`PPS_ENT_RATE_HI:0];
    wire [`PPS_ENT_W-1:0] scan_ent = mem[scan];
    wire scan_hit = scan_ent[`PPS_ENT_FUNC_HI:`PPS_ENT_FUNC_LO] == `PPS_FN_LABEL &&
                    scan_ent[`PPS_ENT_ARG_HI:`PPS_ENT_ARG_LO] == {1'b0, label};
    wire [5:0] scan_next = (scan == `PPS_LAST_IDX) ? 6'h00 : scan + 6'h01;
    wire [5:0] loop_top = loop_stk[loop_sp - 2'h1];

    // apb decode: a write or read takes effect on the edge where pready is seen high
    wire apb_done = psel_in & penable_in & pready_out;
    wire wr = apb_done & pwrite_in;
    wire wr_ctrl = wr && paddr_in == `PPS_REG_CTRL;
    wire wr_key = wr && paddr_in == `PPS_REG_KEY;
    wire wr_edit = wr && paddr_in == `PPS_REG_EDIT;
    wire key_phase = wr_key && pwdata_in[1:0] == `PPS_KEY_PHASE;
    wire key_start = wr_key && pwdata_in[1:0] == `PPS_KEY_START;
    wire key_any = wr_key && pwdata_in[1:0] != 2'h0;
    wire ctl_start = wr_ctrl & pwdata_in[`PPS_CTRL_START];
    wire ctl_stop = wr_ctrl & pwdata_in[`PPS_CTRL_STOP];
    wire ctl_pause = wr_ctrl & pwdata_in[`PPS_CTRL_PAUSE];
    wire foot_rise = (foot_sync[2] == foot_sync[1]) & foot_sync[1] & ~foot_level;
    wire trig = key_start | ctl_start | foot_rise;
    wire [1:0] sp_dec = loop_sp - 2'h1;

    // status word seen by software
    wire [31:0] status_word = {17'h0, buzzer_out, base_valid, edit_armed, oor, prog_error,
                               state != ST_IDLE, state, pc + 6'h01};

    // foot switch: three flops, a change counts once the last two agree
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            foot_sync <= 3'h0;
            foot_level <= 1'b0;
        end else begin
            foot_sync <= {foot_sync[1:0], foot_switch_in};
            if (foot_sync[2] == foot_sync[1])
                foot_level <= foot_sync[1];
        end
    end

    // apb answer: one wait cycle so that read data comes from a flop
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else if (psel_in & penable_in & ~pready_out) begin
            pready_out <= 1'b1;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
            case (paddr_in)
                `PPS_REG_CTRL: prdata_out <= {30'h0, lockout_en, alarm_en};
                `PPS_REG_KEY: prdata_out <= 32'h0;
                `PPS_REG_PSEL: prdata_out <= {26'h0, sel + 6'h01};
                `PPS_REG_PDATA: prdata_out <= {3'h0, mem[sel]};
                `PPS_REG_EDIT: prdata_out <= {30'h0, edit_op};
                `PPS_REG_STATUS: prdata_out <= status_word;
                `PPS_REG_LABEL: prdata_out <= {25'h0, label};
                `PPS_REG_RATE: prdata_out <= {16'h0, pump_rate_out};
                `PPS_REG_TOTALS: prdata_out <= {total_wdraw, total_disp};
                default: pslverr_out <= 1'b1;
            endcase
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // settings, edit timer and the phase store
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alarm_en <= 1'b0;
            lockout_en <= 1'b0;
            sel <= 6'h00;
            label <= `PPS_LABEL_MIN;
            edit_armed <= 1'b0;
            edit_op <= `PPS_EDIT_SELECT;
            edit_cnt <= 28'h0;
            for (i = 0; i < 40; i = i + 1)
                mem[i] <= {`PPS_FN_HALT, 25'h0};
        end else begin
            if (wr_ctrl) begin
                alarm_en <= pwdata_in[`PPS_CTRL_ALARM];
                lockout_en <= pwdata_in[`PPS_CTRL_LOCKOUT];
            end
            if (wr && paddr_in == `PPS_REG_PSEL)
                sel <= phase_index((|pwdata_in[31:8]) ? 8'hff : pwdata_in[7:0]);
            if (wr && paddr_in == `PPS_REG_LABEL &&
                pwdata_in[6:0] >= `PPS_LABEL_MIN && pwdata_in[6:0] <= `PPS_LABEL_MAX)
                label <= pwdata_in[6:0];
            if (wr && paddr_in == `PPS_REG_PDATA && state == ST_IDLE)
                mem[sel] <= pwdata_in[`PPS_ENT_W-1:0];
            // edit arming; any key other than the phase key cancels
            if (wr_edit && state == ST_IDLE && pwdata_in[1:0] != `PPS_EDIT_SELECT) begin
                edit_armed <= 1'b1;
                edit_op <= pwdata_in[1:0];
                edit_cnt <= 28'h0;
            end else if (edit_armed) begin
                edit_cnt <= edit_cnt + 28'h1;
                if (key_any || edit_cnt == EDIT_TIMEOUT_CYC - 28'h1)
                    edit_armed <= 1'b0;
                if (key_phase) begin
                    for (i = 0; i < 40; i = i + 1) begin
                        if (edit_op == `PPS_EDIT_INSERT) begin
                            if (i == sel)
                                mem[i] <= {(sel == 6'h00) ? `PPS_FN_RATE : `PPS_FN_HALT, 25'h0};
                            else if (i > sel)
                                mem[i] <= fix_ref(mem[i - 1], 1'b1, sel);
                            else
                                mem[i] <= fix_ref(mem[i], 1'b1, sel);
                        end else if (edit_op == `PPS_EDIT_REMOVE) begin
                            if (i == 39)
                                mem[i] <= {`PPS_FN_HALT, 25'h0};
                            else if (i >= sel)
                                mem[i] <= fix_ref(mem[i + 1], 1'b0, sel);
                            else
                                mem[i] <= fix_ref(mem[i], 1'b0, sel);
                        end
                    end
                end
            end
        end
    end

    // step executor
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            pc <= 6'h00;
            scan <= 6'h00;
            booted <= 1'b0;
            base_valid <= 1'b0;
            prog_error <= 1'b0;
            stopped <= 1'b0;
            oor <= 1'b0;
            total_disp <= 16'h0;
            total_wdraw <= 16'h0;
            loop_sp <= 2'h0;
            for (j = 0; j < `PPS_LOOP_DEPTH; j = j + 1)
                loop_stk[j] <= 6'h00;
            pump_run_out <= 1'b0;
            pump_dir_out <= 1'b0;
            pump_rate_out <= 16'h0;
            buzzer_out <= 1'b0;
        end else begin
            // buzzer after a stop and while a menu prompt waits
            buzzer_out <= alarm_en && (stopped || state == ST_CHOICE);
            // first control write after reset plays the power-on check
            if (wr_ctrl)
                booted <= 1'b1;
            if (ctl_stop && state != ST_IDLE) begin
                state <= ST_IDLE;
                pc <= 6'h00;
                pump_run_out <= 1'b0;
                stopped <= 1'b1;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (trig || (wr_ctrl && !booted && pwdata_in[`PPS_CTRL_LOCKOUT] &&
                                     mem[0][`PPS_ENT_FUNC_HI:`PPS_ENT_FUNC_LO] == `PPS_FN_CHOICE)) begin
                            state <= ST_EXEC;
                            pc <= 6'h00;
                            base_valid <= 1'b0;
                            prog_error <= 1'b0;
                            stopped <= 1'b0;
                            oor <= 1'b0;
                            loop_sp <= 2'h0;
                        end
                    end
                    ST_EXEC: begin
                        case (cur_fn)
                            `PPS_FN_RATE, `PPS_FN_RAISE, `PPS_FN_LOWER: begin
                                if (cur_fn != `PPS_FN_RATE && !base_valid) begin
                                    state <= ST_IDLE;
                                    pc <= 6'h00;
                                    prog_error <= 1'b1;
                                    stopped <= 1'b1;
                                    pump_run_out <= 1'b0;
                                end else begin
                                    if (cur_fn == `PPS_FN_RAISE)
                                        pump_rate_out <= pump_rate_out + cur_rate;
                                    else if (cur_fn == `PPS_FN_LOWER)
                                        pump_rate_out <= (pump_rate_out > cur_rate) ?
                                                         pump_rate_out - cur_rate : 16'h0;
                                    else
                                        pump_rate_out <= cur_rate;
                                    pump_dir_out <= cur[`PPS_ENT_DIR];
                                    pump_run_out <= 1'b1;
                                    base_valid <= 1'b1;
                                    state <= ST_RUN;
                                end
                            end
                            `PPS_FN_GOTO: pc <= phase_index(cur_arg);
                            `PPS_FN_CHOICE: begin
                                pump_run_out <= 1'b0;
                                state <= ST_CHOICE;
                            end
                            `PPS_FN_OPEN: begin
                                // a looped-back open does not stack itself again
                                if (!(loop_sp != 2'h0 && loop_top == pc) && loop_sp != `PPS_LOOP_DEPTH) begin
                                    loop_stk[loop_sp] <= pc;
                                    loop_sp <= loop_sp + 2'h1;
                                end
                                if (pc == `PPS_LAST_IDX) begin
                                    state <= ST_IDLE;
                                    pc <= 6'h00;
                                    pump_run_out <= 1'b0;
                                    stopped <= 1'b1;
                                end else
                                    pc <= pc + 6'h01;
                            end
                            `PPS_FN_CLOSE: pc <= (loop_sp != 2'h0) ? loop_stk[sp_dec] : 6'h00;
                            `PPS_FN_PAUSE: begin
                                pump_run_out <= 1'b0;
                                base_valid <= 1'b0;
                                state <= ST_PWAIT;
                            end
                            default: begin
                                // halt, label met in sequence, or unknown code
                                state <= ST_IDLE;
                                pc <= 6'h00;
                                pump_run_out <= 1'b0;
                                stopped <= 1'b1;
                            end
                        endcase
                    end
                    ST_RUN: begin
                        if (ctl_pause) begin
                            pump_run_out <= 1'b0;
                            state <= ST_HELD;
                        end else if (cur_arg != 8'h00 && dose_done_in) begin
                            if (cur[`PPS_ENT_DIR])
                                total_wdraw <= total_wdraw + {8'h0, cur_arg};
                            else
                                total_disp <= total_disp + {8'h0, cur_arg};
                            if (pc == `PPS_LAST_IDX) begin
                                state <= ST_IDLE;
                                pc <= 6'h00;
                                pump_run_out <= 1'b0;
                                stopped <= 1'b1;
                            end else begin
                                pc <= pc + 6'h01;
                                state <= ST_EXEC;
                            end
                        end
                    end
                    ST_PWAIT: begin
                        if (trig) begin
                            if (pc == `PPS_LAST_IDX) begin
                                state <= ST_IDLE;
                                pc <= 6'h00;
                                stopped <= 1'b1;
                            end else begin
                                pc <= pc + 6'h01;
                                state <= ST_EXEC;
                            end
                        end else if (key_any) begin
                            state <= ST_IDLE;
                            pc <= 6'h00;
                            stopped <= 1'b1;
                        end
                    end
                    ST_CHOICE: begin
                        if (trig) begin
                            scan <= pc;
                            state <= ST_SEARCH;
                        end
                    end
                    ST_SEARCH: begin
                        if (scan_hit) begin
                            total_disp <= 16'h0;
                            total_wdraw <= 16'h0;
                            if (scan == `PPS_LAST_IDX) begin
                                state <= ST_IDLE;
                                pc <= 6'h00;
                                stopped <= 1'b1;
                            end else begin
                                pc <= scan + 6'h01;
                                state <= ST_EXEC;
                            end
                        end else if (scan_next == pc) begin
                            oor <= 1'b1;
                            state <= ST_OOR;
                        end else
                            scan <= scan_next;
                    end
                    ST_OOR: begin
                        if (key_any) begin
                            oor <= 1'b0;
                            state <= ST_CHOICE;
                        end
                    end
                    ST_HELD: begin
                        if (foot_rise && cur_fn == `PPS_FN_RATE && cur_arg == 8'h00) begin
                            pc <= 6'h00;
                            base_valid <= 1'b0;
                            loop_sp <= 2'h0;
                            state <= ST_EXEC;
                        end else if (trig)
                            state <= ST_EXEC;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // pps_phase_sequencer

//--- pps_seq_chk.sv
// port assertions for the phase program sequencer
`timescale 1ns/1ns
module pps_seq_chk (
    // apb side
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    // pump side
    input wire pump_run_out,
    input wire buzzer_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // exactly one wait state, answer stands one cycle
    AST_RDY_LAT: assert property (psel_in && $rose(penable_in) |=> pready_out) else $error("late ready");
    AST_RDY_PULSE: assert property (pready_out |=> !pready_out) else $error("ready too long");
    AST_RDY_REQ: assert property (pready_out |-> psel_in && penable_in) else $error("ready without access");
    AST_RDY_WAIT: assert property (pready_out |-> $past(psel_in && penable_in)) else $error("no wait state");
    AST_ERR_RDY: assert property (pslverr_out |-> pready_out) else $error("error without ready");
    AST_ERR_DATA: assert property (pslverr_out |-> prdata_out == 32'h0) else $error("error with data");
    // the buzzer only sounds while nothing pumps
    AST_BUZZ_IDLE: assert property (buzzer_out |-> !pump_run_out) else $error("buzz while pumping");
    AST_RST_QUIET: assert property ($rose(rst_n_in) |-> !pump_run_out && !buzzer_out) else $error("busy at reset");
endmodule // pps_seq_chk
bind pps_phase_sequencer pps_seq_chk chk_u (.*);

//--- pps_pump_model.sv
// pump-side partner: reports each dose done after a fixed run time
`timescale 1ns/1ns
module pps_pump_model #(parameter int DOSE_CYC = 4) (
    input wire logic clk_sys_in,
    input wire logic pump_run_in,
    output logic dose_done_out = 1'b0
);
    int cnt = 0;
    // count run time; restart after each delivered dose
    always @(posedge clk_sys_in) begin
        cnt <= (pump_run_in && !dose_done_out) ? cnt + 1 : 0;
        dose_done_out <= pump_run_in && cnt == DOSE_CYC;
    end
endmodule // pps_pump_model

//--- test_phase_program_sequencer.sv
// self-checking bench for the phase program sequencer
`timescale 1ns/1ns
`include "pps_map.vh"
module test_phase_program_sequencer;
    logic clk_sys_in = 0, rst_n_in = 0, psel = 0, pen = 0, pwr = 0, foot = 0, done, serr;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, rd, prdata;
    logic pready, perr, run, dir, buzz;
    logic [15:0] rate;
    int err_count = 0, n_compared = 0;
    // short edit timeout keeps the cancel case quick
    pps_phase_sequencer #(.EDIT_TIMEOUT_CYC(28'd50)) dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(perr), .dose_done_in(done), .foot_switch_in(foot), .pump_run_out(run),
        .pump_dir_out(dir), .pump_rate_out(rate), .buzzer_out(buzz));
    pps_pump_model pm_u (.clk_sys_in(clk_sys_in), .pump_run_in(run), .dose_done_out(done));
    always #5 clk_sys_in = ~clk_sys_in;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_sys_in);
        pen <= 1'b1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        rd = prdata;
        serr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic ent(input logic [31:0] p, input logic [3:0] f, input logic [7:0] a, input logic [15:0] r);
        apb(1, `PPS_REG_PSEL, p);
        apb(1, `PPS_REG_PDATA, {3'h0, f, 1'b0, a, r});
    endtask
    task automatic peek(input logic [31:0] p);
        apb(1, `PPS_REG_PSEL, p);
        apb(0, `PPS_REG_PDATA, 32'h0);
    endtask
    // gap cycles between arming and the key stand in for a slow operator
    task automatic edit(input logic [31:0] p, input logic [1:0] op, input logic [1:0] key, input int gap);
        apb(1, `PPS_REG_PSEL, p);
        apb(1, `PPS_REG_EDIT, op);
        repeat (gap) @(posedge clk_sys_in);
        apb(1, `PPS_REG_KEY, key);
    endtask
    task automatic t_regs;
        apb(0, `PPS_REG_PSEL, 32'h0);
        chk(rd, 32'h1);
        apb(0, 8'h40, 32'h0);
        chk(serr, 1'b1);
        apb(1, `PPS_REG_PSEL, 32'd50);
        apb(0, `PPS_REG_PSEL, 32'h0);
        chk(rd, 32'd40);
    endtask
    task automatic t_edit;
        ent(1, `PPS_FN_GOTO, 8'h03, 16'h0);
        ent(3, `PPS_FN_RATE, 8'h00, 16'h0055);
        edit(1, `PPS_EDIT_INSERT, `PPS_KEY_PHASE, 0);
        peek(1);
        chk(rd[28:25], `PPS_FN_RATE);
        peek(2);
        chk(rd, {3'h0, `PPS_FN_GOTO, 1'b0, 8'h04, 16'h0});
        peek(4);
        chk(rd[15:0], 16'h0055);
        edit(1, `PPS_EDIT_REMOVE, `PPS_KEY_OTHER, 0);
        peek(1);
        chk(rd[28:25], `PPS_FN_RATE);
        edit(1, `PPS_EDIT_REMOVE, `PPS_KEY_PHASE, 60);
        peek(1);
        chk(rd[28:25], `PPS_FN_RATE);
        edit(1, `PPS_EDIT_REMOVE, `PPS_KEY_PHASE, 0);
        peek(1);
        chk(rd, {3'h0, `PPS_FN_GOTO, 1'b0, 8'h03, 16'h0});
    endtask
    task automatic t_rate;
        ent(1, `PPS_FN_RATE, 8'h05, 16'h0100);
        ent(2, `PPS_FN_RAISE, 8'h00, 16'h0010);
        apb(1, `PPS_REG_CTRL, 32'h10);
        repeat (30) @(posedge clk_sys_in);
        chk(rate, 16'h0110);
        apb(1, `PPS_REG_CTRL, 32'h20);
        @(posedge clk_sys_in);
        chk(run, 1'b0);
        ent(1, `PPS_FN_RAISE, 8'h00, 16'h0010);
        apb(1, `PPS_REG_CTRL, 32'h10);
        repeat (10) @(posedge clk_sys_in);
        apb(0, `PPS_REG_STATUS, 32'h0);
        chk({rd[10], run}, 2'b10);
    endtask
    task automatic t_menu;
        ent(1, `PPS_FN_CHOICE, 8'h00, 16'h0);
        ent(5, `PPS_FN_LABEL, 8'h07, 16'h0);
        ent(6, `PPS_FN_RATE, 8'h00, 16'h0200);
        ent(8, `PPS_FN_LABEL, 8'h07, 16'h0);
        ent(9, `PPS_FN_RATE, 8'h00, 16'h0400);
        for (int i = 7; i <= 9; i += 2) begin
            apb(1, `PPS_REG_LABEL, i);
            apb(1, `PPS_REG_CTRL, 32'h21);
            apb(1, `PPS_REG_CTRL, 32'h11);
            repeat (10) @(posedge clk_sys_in);
            chk({buzz, run}, 2'b10);
            apb(1, `PPS_REG_KEY, `PPS_KEY_START);
            repeat (60) @(posedge clk_sys_in);
            apb(0, i == 7 ? `PPS_REG_TOTALS : `PPS_REG_STATUS, 32'h0);
            if (i == 7) chk({rd, rate}, {32'h0, 16'h0200});
            else chk(rd[11], 1'b1);
        end
        apb(1, `PPS_REG_KEY, `PPS_KEY_OTHER);
        apb(0, `PPS_REG_STATUS, 32'h0);
        chk(rd[8:6], 3'h4);
        apb(1, `PPS_REG_CTRL, 32'h20);
        apb(0, `PPS_REG_LABEL, 32'h0);
        chk(rd, 32'd9);
    endtask
    task automatic t_end;
        ent(1, `PPS_FN_GOTO, 8'd40, 16'h0);
        ent(40, `PPS_FN_RATE, 8'h01, 16'h0300);
        apb(1, `PPS_REG_CTRL, 32'h11);
        repeat (30) @(posedge clk_sys_in);
        chk({run, buzz}, 2'b01);
        apb(0, `PPS_REG_TOTALS, 32'h0);
        chk(rd, 32'h1);
        ent(2, `PPS_FN_RATE, 8'h00, 16'h0300);
        ent(1, `PPS_FN_RATE, 8'h01, 16'h0100);
        apb(1, `PPS_REG_CTRL, 32'h10);
        repeat (30) @(posedge clk_sys_in);
        apb(1, `PPS_REG_CTRL, 32'h40);
        foot <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        chk(rate, 16'h0100);
        foot <= 1'b0;
        rst_n_in <= 1'b0;
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        ent(1, `PPS_FN_CHOICE, 8'h00, 16'h0);
        apb(1, `PPS_REG_CTRL, 32'h3);
        repeat (10) @(posedge clk_sys_in);
        chk({buzz, run}, 2'b10);
    endtask
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // main sequence after a 10-cycle reset
    initial begin
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_regs;
        t_edit;
        t_rate;
        t_menu;
        t_end;
        give_verdict;
    end
    // watchdog well past the expected several hundred cycles
    initial begin
        #200000;
        err_count++;
        give_verdict;
    end
endmodule // test_phase_program_sequencer
